// ===== rtl/wqd_pkg.sv
// shared constants for the work queue dispatch and qos block
package wqd_pkg;
  localparam int PRIO_W      = 4;
  localparam int TOK_W       = 8;
  localparam int TC_W        = 3;
  localparam int ST_W        = 8;
  localparam int STSEL_W     = 3;
  localparam int OP_W        = 4;
  localparam int DESC_W      = 32;
  localparam int TOTAL_TOKENS = 74;
  localparam int TOK_PER_ENG = 4;
  // descriptor field positions
  localparam int D_OP_LO     = 0;
  localparam int D_SRCTC     = 4;
  localparam int D_DSTTC     = 5;
  localparam int D_STRICT    = 6;
  localparam int D_CACHE     = 7;
  localparam int D_STSEL_LO  = 8;
  // operation codes
  localparam logic [OP_W-1:0] OP_NOP   = 4'h0;
  localparam logic [OP_W-1:0] OP_MOVE  = 4'h3;
  localparam logic [OP_W-1:0] OP_FILL  = 4'h4;
  localparam logic [OP_W-1:0] OP_CMP   = 4'h5;
  localparam logic [OP_W-1:0] OP_FLUSH = 4'h8;
  localparam logic [PRIO_W-1:0] PRIO_ZERO = 4'h0;
  localparam logic [PRIO_W-1:0] PRIO_ONE  = 4'h1;
  // payload pushed toward the engines
  localparam int OUT_W = DESC_W + 2*TC_W + ST_W + 3;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    WQD_RUN    = 2'b00,
    WQD_RELOAD = 2'b01
  } wqd_arb_t;
endpackage

// ===== rtl/wqd_fifo.sv
// flop-based fifo with valid/ready on both sides
module wqd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  logic             doPush;
  logic             doPop;

  assign inReady  = (fill != (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fill <= '0;
    end else if (doPush && !doPop) begin
      fill <= fill + 1'b1;
    end else if (doPop && !doPush) begin
      fill <= fill - 1'b1;
    end
  end
endmodule

// ===== rtl/wqd_rr_pick.sv
// round robin finder: first request at or after the pointer
module wqd_rr_pick #(
  parameter int N = 4
) (
  input  wire logic [N-1:0]         req,
  input  wire logic [$clog2(N)-1:0] ptr,
  output logic                      found,
  output logic      [$clog2(N)-1:0] idx
);
  localparam int IW = $clog2(N);

  function automatic logic [IW:0] wqd_first(input logic [N-1:0] r,
                                            input logic [IW-1:0] p);
    logic [IW:0] res;
    int          k;
    res = '0;
    for (int i = N-1; i >= 0; i--) begin
      k = (int'(p) + i) % N;
      if (r[k]) begin
        res = {1'b1, IW'(k)};
      end
    end
    return res;
  endfunction

  // whole scan in one cycle, so empty queues cost no turn
  assign {found, idx} = wqd_first(req, ptr);
endmodule

// ===== rtl/wqd_dispatch_qos.sv
// What this block does
// - priorities 1..15, weighed within this group only
// - per-queue counter loaded, decremented per dispatch
// - arbiter visits queues, one descriptor each
// - zero counter blocks queue until reload
// - all pending counters zero reloads every counter
// - newly filled queue served at next turn unless its counter is zero
// - skipping empty queues costs no cycles
// - per-buffer flag picks first or second class
// - reserved tokens skip shared-pool check, not global limit
// - group held tokens never exceed allowed
// - total token count reported as constant
// - global-limit groups share one token pool
// - writes carry steering tag from table
// - strict flag marks writes as unordered-forbidden
// - write hint: zero memory, one cache
// - flush hint: zero invalidates, one keeps
// - hint meaningless for other operations
module wqd_dispatch_qos
  import wqd_pkg::*;
#(
  parameter int NWQ  = 4,
  parameter int NST  = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // work queue side
  input  wire logic [NWQ-1:0]         wqEnable,
  input  wire logic [NWQ-1:0]         wqReset,
  input  wire logic [NWQ*PRIO_W-1:0]  wqPriority,
  input  wire logic [NWQ-1:0]         wqValid,
  input  wire logic [NWQ*DESC_W-1:0]  wqDesc,
  output logic      [NWQ-1:0]         wqTake,
  // group configuration
  input  wire logic [TC_W-1:0]        firstTrafficClass,
  input  wire logic [TC_W-1:0]        secondTrafficClass,
  input  wire logic [NST*ST_W-1:0]    steerTable,
  input  wire logic [TOK_W-1:0]       tokReserved,
  input  wire logic [TOK_W-1:0]       tokAllowed,
  input  wire logic [TOK_W-1:0]       sumReserved,
  input  wire logic                   useGlobalLimit,
  input  wire logic [TOK_W-1:0]       globalTokenLimit,
  // token usage of the other groups
  input  wire logic [TOK_W-1:0]       otherUnresvUsed,
  input  wire logic [TOK_W-1:0]       otherGlobalUsed,
  // engine side
  output logic                        engValid,
  input  wire logic                   engReady,
  output logic      [DESC_W-1:0]      engDesc,
  output logic      [TC_W-1:0]        engSrcClass,
  output logic      [TC_W-1:0]        engDstClass,
  output logic      [ST_W-1:0]        engSteerTag,
  output logic                        engStrictOrder,
  output logic                        engCacheAlloc,
  output logic                        engFlushKeep,
  // token acquisition by engines
  input  wire logic                   tokReq,
  input  wire logic [TOK_W-1:0]       tokReqCount,
  output logic                        tokGrant,
  input  wire logic                   tokRelease,
  input  wire logic [TOK_W-1:0]       tokRelCount,
  // status
  output logic      [TOK_W-1:0]       tokHeld,
  output logic      [TOK_W-1:0]       unresvUsed,
  output logic      [TOK_W-1:0]       capTotalTokens
);
  localparam int IW = $clog2(NWQ);

  wqd_arb_t            arbState;
  logic [PRIO_W-1:0]   wqCount [NWQ];
  logic [NWQ-1:0]      cntNonZero;
  logic [NWQ-1:0]      eligible;
  logic [NWQ-1:0]      pending;
  logic [IW-1:0]       turnPtr;
  logic [IW-1:0]       pickIdx;
  logic                pickFound;
  logic                reloadAll;
  logic                doDispatch;
  logic                fifoInReady;
  logic [OUT_W-1:0]    fifoIn;
  logic [OUT_W-1:0]    fifoOut;
  logic [DESC_W-1:0]   selDesc;
  logic [OP_W-1:0]     selOp;
  logic                selWrites;
  logic                selFlush;
  logic [STSEL_W-1:0]  selStSel;
  logic [TC_W-1:0]     selSrcTc;
  logic [TC_W-1:0]     selDstTc;
  logic [ST_W-1:0]     selSt;
  logic                selStrict;
  logic                selAlloc;
  logic                selKeep;
  logic [TOK_W:0]      heldAfter;
  logic [TOK_W:0]      excessAfter;
  logic [TOK_W:0]      excessNow;
  logic [TOK_W:0]      unresvPool;
  logic [TOK_W:0]      globalAfter;
  logic                fitsAllowed;
  logic                fitsShared;
  logic                fitsGlobal;

  function automatic logic [PRIO_W-1:0] wqd_prio(input int q,
      input logic [NWQ*PRIO_W-1:0] p);
    return p[q*PRIO_W +: PRIO_W];
  endfunction

  assign capTotalTokens = TOK_W'(TOTAL_TOKENS);

  // ---------------- arbitration ----------------
  assign pending   = wqValid & wqEnable;
  assign eligible  = pending & cntNonZero;
  assign reloadAll = (pending != '0) && (eligible == '0);
  // the reload edge itself is the only idle turn, so no state gating here
  assign doDispatch = pickFound && fifoInReady;

  wqd_rr_pick #(
    .N     (NWQ)
  ) u_pick (
    .req   (eligible),
    .ptr   (turnPtr),
    .found (pickFound),
    .idx   (pickIdx)
  );

  genvar g;
  generate
    for (g = 0; g < NWQ; g++) begin : gen_wq
      logic enPrev;
      assign cntNonZero[g] = (wqCount[g] != PRIO_ZERO);
      assign wqTake[g] = doDispatch && (pickIdx == IW'(g));

      always_ff @(posedge clk) begin
        if (rst) begin
          enPrev <= 1'b0;
        end else begin
          enPrev <= wqEnable[g];
        end
      end

      // counters only weigh queues of this group against each other
      always_ff @(posedge clk) begin
        if (rst) begin
          wqCount[g] <= PRIO_ZERO;
        end else if (wqReset[g] || (wqEnable[g] && !enPrev)) begin
          wqCount[g] <= wqd_prio(g, wqPriority);
        end else if (reloadAll) begin
          wqCount[g] <= wqd_prio(g, wqPriority);
        end else if (wqTake[g]) begin
          wqCount[g] <= wqCount[g] - PRIO_ONE;
        end
      end
    end
  endgenerate

  // reload spends one cycle, only when nothing is eligible anyway
  always_ff @(posedge clk) begin
    if (rst) begin
      arbState <= WQD_RUN;
    end else begin
      case (arbState)
        WQD_RUN:    arbState <= reloadAll ? WQD_RELOAD : WQD_RUN;
        WQD_RELOAD: arbState <= WQD_RUN;
        default:    arbState <= WQD_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      turnPtr <= '0;
    end else if (doDispatch) begin
      turnPtr <= (pickIdx == IW'(NWQ-1)) ? '0 : pickIdx + 1'b1;
    end
  end

  // ---------------- descriptor tagging ----------------
  assign selDesc   = wqDesc[pickIdx*DESC_W +: DESC_W];
  assign selOp     = selDesc[D_OP_LO +: OP_W];
  assign selWrites = (selOp == OP_MOVE) || (selOp == OP_FILL);
  assign selFlush  = (selOp == OP_FLUSH);
  assign selStSel  = selDesc[D_STSEL_LO +: STSEL_W];
  assign selSrcTc  = selDesc[D_SRCTC] ? secondTrafficClass
                                      : firstTrafficClass;
  assign selDstTc  = selDesc[D_DSTTC] ? secondTrafficClass
                                      : firstTrafficClass;
  assign selSt     = steerTable[selStSel*ST_W +: ST_W];
  assign selStrict = selDesc[D_STRICT] && (selWrites || selFlush);
  // the hint is carried but the fabric may still ignore it
  assign selAlloc  = selWrites && selDesc[D_CACHE];
  assign selKeep   = selFlush && selDesc[D_CACHE];
  assign fifoIn = {selDesc, selSrcTc, selDstTc, selSt,
                   selStrict, selAlloc, selKeep};

  wqd_fifo #(
    .WIDTH    (OUT_W),
    .DEPTH    (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (doDispatch),
    .inReady  (fifoInReady),
    .inData   (fifoIn),
    .outValid (engValid),
    .outReady (engReady),
    .outData  (fifoOut)
  );

  assign {engDesc, engSrcClass, engDstClass, engSteerTag,
          engStrictOrder, engCacheAlloc, engFlushKeep} = fifoOut;

  // ---------------- bandwidth tokens ----------------
  assign heldAfter   = {1'b0, tokHeld} + {1'b0, tokReqCount};
  assign excessNow   = (tokHeld > tokReserved)
                     ? {1'b0, tokHeld} - {1'b0, tokReserved} : '0;
  assign excessAfter = (heldAfter > {1'b0, tokReserved})
                     ? heldAfter - {1'b0, tokReserved} : '0;
  assign unresvPool  = (TOK_W+1)'(TOTAL_TOKENS) - {1'b0, sumReserved};
  assign globalAfter = {1'b0, otherGlobalUsed} + heldAfter;
  assign fitsAllowed = heldAfter <= {1'b0, tokAllowed};
  // tokens within the reserve never compete for the shared unreserved pool
  assign fitsShared  = (excessAfter == '0) ||
    ({1'b0, otherUnresvUsed} + excessAfter <= unresvPool);
  assign fitsGlobal  = !useGlobalLimit ||
    (globalAfter <= {1'b0, globalTokenLimit});
  // request held by the engine until granted; nothing is dropped
  assign tokGrant = tokReq && fitsAllowed && fitsShared && fitsGlobal;
  assign unresvUsed = excessNow[TOK_W-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      tokHeld <= '0;
    end else if (tokGrant && tokRelease) begin
      tokHeld <= heldAfter[TOK_W-1:0] - tokRelCount;
    end else if (tokGrant) begin
      tokHeld <= heldAfter[TOK_W-1:0];
    end else if (tokRelease) begin
      tokHeld <= (tokRelCount > tokHeld) ? '0 : tokHeld - tokRelCount;
    end
  end

  // ---------------- checks ----------------
  logic [IW-1:0]     takeIdx;
  logic [PRIO_W-1:0] takeCnt;
  assign takeIdx = pickIdx;
  assign takeCnt = wqCount[pickIdx];

  sequence s_take;
    doDispatch && !reloadAll && (wqReset == '0) && (wqEnable == $past(wqEnable));
  endsequence
  sequence s_dec_seen;
    ##1 (wqCount[$past(takeIdx)] == $past(takeCnt) - PRIO_ONE);
  endsequence

  a_take_decrements: assert property (@(posedge clk) disable iff (rst)
    s_take |-> s_dec_seen)
    else $error("dispatch did not decrement queue counter");

  a_zero_blocks: assert property (@(posedge clk) disable iff (rst)
    doDispatch |-> (wqCount[pickIdx] != PRIO_ZERO))
    else $error("dispatch from queue with zero counter");

  a_reload_loads: assert property (@(posedge clk) disable iff (rst)
    (reloadAll && (wqReset == '0) && ($past(wqEnable) == wqEnable))
    |=> (wqCount[0] == wqd_prio(0, $past(wqPriority))))
    else $error("reload did not restore priority");

  a_no_idle_turn: assert property (@(posedge clk) disable iff (rst)
    ((eligible != '0) && fifoInReady)
    |-> doDispatch ##1 (arbState == WQD_RUN))
    else $error("arbiter idled with eligible work");

  a_class_choice: assert property (@(posedge clk) disable iff (rst)
    doDispatch |-> (selSrcTc == (selDesc[D_SRCTC] ? secondTrafficClass
                                 : firstTrafficClass)))
    else $error("source class not chosen by selector");

  a_tok_cap: assert property (@(posedge clk) disable iff (rst)
    tokGrant |-> (heldAfter <= {1'b0, tokAllowed}))
    else $error("grant exceeds allowed tokens");

  a_global_pool: assert property (@(posedge clk) disable iff (rst)
    (tokGrant && useGlobalLimit)
    |-> (globalAfter <= {1'b0, globalTokenLimit}))
    else $error("grant exceeds shared pool");

  a_hint_reserved: assert property (@(posedge clk) disable iff (rst)
    (doDispatch && !selWrites && !selFlush)
    |-> !selAlloc && !selKeep)
    else $error("cache hint used for other operation");

  a_strict_mark: assert property (@(posedge clk) disable iff (rst)
    (doDispatch && selWrites && selDesc[D_STRICT]) |-> selStrict)
    else $error("strict write not marked");

  a_grant_held: assert property (@(posedge clk) disable iff (rst)
    (tokGrant && !tokRelease) |=> (tokHeld == $past(heldAfter[TOK_W-1:0])))
    else $error("granted tokens not accounted");
endmodule

// ===== tb/wqd_engine_model.sv
// engine side model: takes dispatched descriptors, may stall
module wqd_engine_model
  import wqd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              stall,
  input  wire logic              engValid,
  output logic                   engReady,
  input  wire logic [DESC_W-1:0] engDesc,
  input  wire logic [TC_W-1:0]   engSrcClass,
  input  wire logic [TC_W-1:0]   engDstClass,
  input  wire logic [ST_W-1:0]   engSteerTag,
  input  wire logic              engStrictOrder,
  input  wire logic              engCacheAlloc,
  input  wire logic              engFlushKeep,
  output logic      [OUT_W-1:0]  got,
  output int                     popCount
);
  timeunit 1ns;
  timeprecision 100ps;

  always_ff @(posedge clk) begin
    if (rst) begin
      engReady <= 1'b0;
      popCount <= 0;
    end else begin
      // ready moves only after an edge, like a real engine
      engReady <= !stall;
      if (engValid && engReady) begin
        got      <= {engDesc, engSrcClass, engDstClass, engSteerTag,
                     engStrictOrder, engCacheAlloc, engFlushKeep};
        popCount <= popCount + 1;
      end
    end
  end
endmodule

// ===== tb/wqd_dispatch_qos_tb.sv
// self-checking bench for the dispatch and qos block
module wqd_dispatch_qos_tb
  import wqd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NQ = 4;
  logic clk = 1'b0, rst = 1'b1, stall = 1'b0;
  logic [NQ-1:0] wqEnable = '0, wqReset = '0, wqValid, wqTake;
  logic [NQ*PRIO_W-1:0] wqPriority = '0;
  logic [NQ*DESC_W-1:0] wqDesc;
  logic [TC_W-1:0] firstTrafficClass = 3'h2, secondTrafficClass = 3'h5;
  logic [8*ST_W-1:0] steerTable;
  logic [TOK_W-1:0] tokReserved = 8'h04, tokAllowed = 8'h08;
  logic [TOK_W-1:0] sumReserved = 8'h04, globalTokenLimit = 8'h10;
  logic [TOK_W-1:0] otherUnresvUsed = '0, otherGlobalUsed = '0;
  logic [TOK_W-1:0] tokReqCount = '0, tokRelCount = '0;
  logic [TOK_W-1:0] tokHeld, unresvUsed, capTotalTokens;
  logic useGlobalLimit = 1'b0, tokReq = 1'b0, tokRelease = 1'b0;
  logic engValid, engReady, engStrictOrder, engCacheAlloc, engFlushKeep;
  logic tokGrant;
  logic [DESC_W-1:0] engDesc;
  logic [TC_W-1:0] engSrcClass, engDstClass;
  logic [ST_W-1:0] engSteerTag;
  logic [OUT_W-1:0] got;
  int popCount;
  logic [7:0] pend [NQ];
  logic [DESC_W-1:0] head [NQ];
  logic [NQ-1:0] loadMask = '0;
  logic [7:0] loadN;
  logic [DESC_W-1:0] loadD;
  int cyc = 0, err_count = 0, n_compared = 0;
  int takeT[$], takeQ[$];

  always #2.5 clk = ~clk;

  wqd_dispatch_qos #(.NWQ(NQ), .NST(8)) dut (.clk, .rst, .wqEnable,
    .wqReset, .wqPriority, .wqValid, .wqDesc, .wqTake, .firstTrafficClass,
    .secondTrafficClass, .steerTable, .tokReserved, .tokAllowed,
    .sumReserved, .useGlobalLimit, .globalTokenLimit, .otherUnresvUsed,
    .otherGlobalUsed, .engValid, .engReady, .engDesc, .engSrcClass,
    .engDstClass, .engSteerTag, .engStrictOrder, .engCacheAlloc,
    .engFlushKeep, .tokReq, .tokReqCount, .tokGrant, .tokRelease,
    .tokRelCount, .tokHeld, .unresvUsed, .capTotalTokens);

  wqd_engine_model eng (.clk, .rst, .stall, .engValid, .engReady, .engDesc,
    .engSrcClass, .engDstClass, .engSteerTag, .engStrictOrder,
    .engCacheAlloc, .engFlushKeep, .got, .popCount);

  // queue heads pop on the edge that sees a take
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      wqValid[q] = (pend[q] != 8'h00);
      wqDesc[q*DESC_W +: DESC_W] = head[q];
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
    for (int q = 0; q < NQ; q++) begin
      if (wqTake[q] === 1'b1) begin
        takeT.push_back(cyc);
        takeQ.push_back(q);
      end
      if (loadMask[q]) begin
        pend[q] <= loadN;
        head[q] <= loadD;
      end else if (wqTake[q] === 1'b1) pend[q] <= pend[q] - 8'h01;
    end
  end

  task automatic end_sim();
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic push(input logic [NQ-1:0] m, input logic [DESC_W-1:0] d,
                      input logic [7:0] n);
    @(posedge clk);
    loadMask <= m;
    loadN <= n;
    loadD <= d;
    @(posedge clk);
    loadMask <= '0;
  endtask

  task automatic tok_try(input logic [TOK_W-1:0] n, output logic g,
                         output int w);
    g = 1'b0;
    w = 0;
    @(posedge clk);
    tokReq <= 1'b1;
    tokReqCount <= n;
    while (!g && w < 40) begin
      @(negedge clk);
      w++;
      g = (tokGrant === 1'b1);
      @(posedge clk);
    end
    tokReq <= 1'b0;
  endtask

  task automatic rel(input logic [TOK_W-1:0] n);
    @(posedge clk);
    tokRelease <= 1'b1;
    tokRelCount <= n;
    @(posedge clk);
    tokRelease <= 1'b0;
  endtask

  // request held while another party frees room six edges later
  task automatic tok_stall(input int code);
    logic g;
    int w;
    fork
      tok_try(8'h04, g, w);
      begin
        repeat (6) @(posedge clk);
        case (code)
          0: rel(8'h04);
          1: otherUnresvUsed <= 8'h42;
          default: otherGlobalUsed <= 8'h0c;
        endcase
      end
    join
    check(g, 1'b1);
    check(w >= 6 && w < 10, 1'b1);
  endtask

  function automatic logic [DESC_W-1:0] mkd(input logic [OP_W-1:0] op,
                                            input logic [3:0] f,
                                            input logic [2:0] sel);
    mkd = 32'h5a000000;
    mkd[D_OP_LO +: OP_W] = op;
    mkd[D_SRCTC] = f[0];
    mkd[D_DSTTC] = f[1];
    mkd[D_STRICT] = f[2];
    mkd[D_CACHE] = f[3];
    mkd[D_STSEL_LO +: STSEL_W] = sel;
  endfunction

  initial begin
    logic [OP_W-1:0] ops [4];
    logic [OP_W-1:0] op;
    logic [DESC_W-1:0] d;
    logic [3:0] f;
    logic wr, fl, g;
    int base, w, n0;
    ops = '{OP_MOVE, OP_FILL, OP_FLUSH, OP_CMP};
    for (int e = 0; e < 8; e++) steerTable[e*ST_W +: ST_W] = 8'ha0 + e;
    for (int q = 0; q < NQ; q++) pend[q] = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wqPriority <= {4'h2, 4'h1, 4'h1, 4'h3};
    @(negedge clk);
    check(engValid, 1'b0);
    check(tokHeld, 8'h00);
    check(capTotalTokens, TOTAL_TOKENS);
    @(posedge clk);
    wqEnable <= 4'hf;
    repeat (2) @(posedge clk);
    push(4'h3, mkd(OP_MOVE, 4'h0, 3'h0), 8'd40);
    for (int k = 0; k < 100 && takeT.size() < 8; k++) @(negedge clk);
    n0 = 0;
    for (int k = 0; k < 8; k++) n0 += (takeQ[k] == 0);
    check(n0, 6);
    // two rounds of four plus one reload cycle, no gaps for empty queues
    check(takeT[7] - takeT[0], 8);
    push(4'h3, '0, 8'd0);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      op = ops[i % 4];
      f = {i[2], i[0] ^ i[2], i[1], i[0]};
      d = mkd(op, f, i[2:0]);
      wr = (op == OP_MOVE || op == OP_FILL);
      fl = (op == OP_FLUSH);
      base = popCount;
      push(4'h4, d, 8'd1);
      for (int k = 0; k < 30 && popCount == base; k++) @(negedge clk);
      check(got, {d, f[0] ? 3'h5 : 3'h2, f[1] ? 3'h5 : 3'h2,
                  8'ha0 + i[2:0], f[2] && (wr || fl), f[3] && wr,
                  f[3] && fl});
    end
    // class unknown to software: both settings hold the same class
    firstTrafficClass <= 3'h5;
    base = popCount;
    push(4'h4, mkd(OP_CMP, 4'h0, 3'h0), 8'd1);
    for (int k = 0; k < 30 && popCount == base; k++) @(negedge clk);
    check(got[16:14], 3'h5);
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    base = takeT.size();
    w = popCount;
    push(4'h1, mkd(OP_FILL, 4'h0, 3'h1), 8'd20);
    repeat (40) @(posedge clk);
    @(negedge clk);
    check(takeT.size() - base, FIFO_DEPTH);
    check(engValid, 1'b1);
    stall <= 1'b0;
    for (int k = 0; k < 300 && popCount < w + 20; k++) @(negedge clk);
    check(popCount - w, 20);
    check(pend[0], 8'h00);
    // allowed 8, reserve 4, sum of reserves within total
    tok_try(8'h04, g, w);
    check(g, 1'b1);
    tok_try(8'h04, g, w);
    @(negedge clk);
    check(tokHeld, 8'h08);
    tok_stall(0);
    @(negedge clk);
    check(tokHeld, 8'h08);
    rel(8'h08);
    otherUnresvUsed <= 8'h46;
    tok_try(8'h04, g, w);
    check(g, 1'b1);
    tok_stall(1);
    @(negedge clk);
    check(unresvUsed, 8'h04);
    rel(8'h08);
    @(posedge clk);
    // global pool of 16 covers four engines
    useGlobalLimit <= 1'b1;
    otherUnresvUsed <= 8'h00;
    otherGlobalUsed <= 8'h0e;
    @(negedge clk);
    check(tokHeld, 8'h00);
    tok_stall(2);
    @(negedge clk);
    check(tokHeld, 8'h04);
    end_sim();
  end
endmodule
